// ===== eac_defines.vh
/*
 * constants of the byte-wide data store controller: register offsets,
 * control field positions, reset values and timing counts.
 * assumes inclusion by bare name from the controller sources.
 */
`ifndef EAC_DEFINES_VH
`define EAC_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// register byte addresses (word aligned, axi4-lite)
`define EAC_OFS_ADDR_LOW   8'h04
`define EAC_OFS_ADDR_HIGH  8'h08
`define EAC_OFS_VALUE      8'h0C
`define EAC_OFS_CTRL       8'h10
`define EAC_OFS_STATUS     8'h14

////////////////////////////////////////////////////////////////////////////
// control register fields
`define EAC_CTRL_READ      0
`define EAC_CTRL_PROG      1
`define EAC_CTRL_ARM       2
`define EAC_CTRL_RDY_IE    3
`define EAC_CTRL_MODE_LO   4
`define EAC_CTRL_MODE_HI   5

// mode encodings
`define EAC_MODE_ATOMIC    2'b00
`define EAC_MODE_ERASE     2'b01
`define EAC_MODE_WRITE     2'b10
`define EAC_MODE_RSVD      2'b11
`define EAC_MODE_RESET     2'b00

////////////////////////////////////////////////////////////////////////////
// timing, erased byte value and response codes
`define EAC_ARM_CYCLES     4
`define EAC_RD_STALL       4
`define EAC_WR_STALL       2
`define EAC_ERASED_BYTE    8'hFF
`define EAC_RESP_OKAY      2'b00
`define EAC_RESP_SLVERR    2'b10

`endif

// ===== eac_tick_div.v
/*
 * divider standing in for the calibrated internal oscillator: gives a
 * one-cycle tick every DIV clocks.
 * assumes one clock domain; never reset by the controller soft reset so
 * a running program keeps its time base.
 */
`timescale 1ns/1ps
`default_nettype none

module eac_tick_div #(
    parameter integer DIV = 250
) (
    input  wire        aclk,
    input  wire        por_n,
    output reg         tick
);
    reg [15:0] cnt_q;

    always @(posedge aclk) begin
        if (!por_n) begin
            cnt_q <= 16'h0000;
            tick  <= 1'b0;
        end else if (cnt_q == DIV[15:0] - 16'h0001) begin
            cnt_q <= 16'h0000;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ===== eac_ctrl.v
/*
 * data store access controller: address, value and control registers
 * behind an axi4-lite slave, byte array storage, arm/strobe programming,
 * oscillator-timed busy, core stall and ready request.
 * assumes a single 250 MHz clock; por_n is the power-on reset which
 * alone may abort programming, aresetn is the system reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "eac_defines.vh"

// Overview of operation
// - store is its own byte array, one byte read or written at a time
// - address, value and control registers sit in the register space
// - a read stalls the core for four clock cycles
// - starting programming stalls the core for two clock cycles
// - mode 00 strobe within four cycles of arming: erase plus write
// - strobe stays set until the atomic operation ends
// - mode 01 strobe within arm window erases only; strobe held till done
// - mode 10 strobe within arm window writes only; strobe held till done
// - write-only on an unerased byte leaves stored value undefined
// - no other operation starts while programming runs
// - programming is timed by oscillator ticks, not the core clock
// - reset does not abort programming in progress
// - arm self-clears after four cycles; strobe without arm does nothing
// - mode writes ignored while strobe set; reset clears mode unless busy
// - read strobe loads value at once; reads and address blocked when busy
// - ready request held high while enabled and idle
module eac_ctrl #(
    parameter integer ADDR_W      = 9,
    parameter integer TICK_DIV    = 250,
    parameter integer T_ATOMIC    = 3400,
    parameter integer T_SPLIT     = 1800
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        por_n,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         core_stall,
    output reg         ready_irq
);
    localparam integer DEPTH = 1 << ADDR_W;
    localparam integer ARM_N  = `EAC_ARM_CYCLES;
    localparam integer RD_M1  = `EAC_RD_STALL - 1;
    localparam integer WR_M1  = `EAC_WR_STALL - 1;

    ////////////////////////////////////////////////////////////////////////
    // state
    reg [7:0]        mem_q [0:DEPTH-1];
    reg [ADDR_W-1:0] addr_q;
    reg [7:0]        value_q;
    reg [1:0]        mode_q;
    reg              arm_q;
    reg [2:0]        arm_cnt_q;
    reg              prog_q;
    reg              rdy_ie_q;
    reg [15:0]       ticks_q;
    reg [1:0]        op_mode_q;
    reg [ADDR_W-1:0] op_addr_q;
    reg [7:0]        op_value_q;
    reg [2:0]        stall_q;
    reg              aw_got_q;
    reg              w_got_q;
    reg [7:0]        aw_q;
    reg [31:0]       wd_q;
    reg [3:0]        ws_q;
    wire             tick;

    // oscillator stand-in: por only, so soft reset keeps time running
    eac_tick_div #(
        .DIV (TICK_DIV)
    ) u_div (
        .aclk  (aclk),
        .por_n (por_n),
        .tick  (tick)
    );

    function [15:0] prog_ticks;
        input [1:0] m;
        begin
            case (m)
                `EAC_MODE_ATOMIC: prog_ticks = T_ATOMIC[15:0];
                `EAC_MODE_ERASE:  prog_ticks = T_SPLIT[15:0];
                `EAC_MODE_WRITE:  prog_ticks = T_SPLIT[15:0];
                default:          prog_ticks = 16'h0000;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // axi write capture, either order
    wire        wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
    wire        wr_low  = wr_fire && aw_q == `EAC_OFS_ADDR_LOW && ws_q[0];
    wire        wr_high = wr_fire && aw_q == `EAC_OFS_ADDR_HIGH && ws_q[0];
    wire        wr_val  = wr_fire && aw_q == `EAC_OFS_VALUE && ws_q[0];
    wire        wr_ctl  = wr_fire && aw_q == `EAC_OFS_CTRL && ws_q[0];
    wire        wr_map  = aw_q == `EAC_OFS_ADDR_LOW || aw_q == `EAC_OFS_ADDR_HIGH
                       || aw_q == `EAC_OFS_VALUE || aw_q == `EAC_OFS_CTRL
                       || aw_q == `EAC_OFS_STATUS;
    wire        set_prog = wr_ctl && wd_q[`EAC_CTRL_PROG];
    wire        set_read = wr_ctl && wd_q[`EAC_CTRL_READ];
    wire        start    = set_prog && arm_q && !prog_q
                        && mode_q != `EAC_MODE_RSVD;
    wire        do_read  = set_read && !prog_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `EAC_RESP_OKAY;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            aw_q          <= 8'h00;
            wd_q          <= 32'h0000_0000;
            ws_q          <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q          <= s_axi_awaddr;
                aw_got_q      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_q         <= s_axi_wdata;
                ws_q         <= s_axi_wstrb;
                w_got_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? `EAC_RESP_OKAY : `EAC_RESP_SLVERR;
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software-visible registers under system reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            addr_q    <= {ADDR_W{1'b0}};
            value_q   <= 8'h00;
            rdy_ie_q  <= 1'b0;
            arm_q     <= 1'b0;
            arm_cnt_q <= 3'd0;
            if (!prog_q)
                mode_q <= `EAC_MODE_RESET;
        end else begin
            // arm window counts down and self-clears
            if (wr_ctl && wd_q[`EAC_CTRL_ARM]) begin
                arm_q     <= 1'b1;
                arm_cnt_q <= ARM_N[2:0];
            end else if (arm_q) begin
                if (arm_cnt_q == 3'd1)
                    arm_q <= 1'b0;
                arm_cnt_q <= arm_cnt_q - 3'd1;
            end
            if (start)
                arm_q <= 1'b0;
            if (wr_ctl) begin
                rdy_ie_q <= wd_q[`EAC_CTRL_RDY_IE];
                if (!prog_q && !start)
                    mode_q <= wd_q[`EAC_CTRL_MODE_HI:`EAC_CTRL_MODE_LO];
            end
            // address frozen while programming
            if (!prog_q) begin
                if (wr_low)
                    addr_q[7:0] <= wd_q[7:0];
                if (wr_high && ADDR_W > 8)
                    addr_q[ADDR_W-1:8] <= wd_q[ADDR_W-9:0];
            end
            if (wr_val)
                value_q <= wd_q[7:0];
            else if (do_read)
                value_q <= mem_q[addr_q];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // programming engine: only power-on reset stops it
    always @(posedge aclk) begin
        if (!por_n) begin
            prog_q     <= 1'b0;
            ticks_q    <= 16'h0000;
            op_mode_q  <= `EAC_MODE_ATOMIC;
            op_addr_q  <= {ADDR_W{1'b0}};
            op_value_q <= 8'h00;
        end else if (start) begin
            prog_q     <= 1'b1;
            ticks_q    <= prog_ticks(mode_q);
            op_mode_q  <= mode_q;
            op_addr_q  <= addr_q;
            op_value_q <= value_q;
        end else if (prog_q && tick) begin
            if (ticks_q == 16'h0001)
                prog_q <= 1'b0;
            ticks_q <= ticks_q - 16'h0001;
        end
    end

    // storage commits at the end of the timed operation
    always @(posedge aclk) begin
        if (prog_q && tick && ticks_q == 16'h0001) begin
            case (op_mode_q)
                `EAC_MODE_ATOMIC: mem_q[op_addr_q] <= op_value_q;
                `EAC_MODE_ERASE:  mem_q[op_addr_q] <= `EAC_ERASED_BYTE;
                // flash-like: bits only fall, unerased byte is garbage
                `EAC_MODE_WRITE:  mem_q[op_addr_q] <= mem_q[op_addr_q]
                                                      & op_value_q;
                default:          mem_q[op_addr_q] <= mem_q[op_addr_q];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core stall and ready request
    always @(posedge aclk) begin
        if (!aresetn) begin
            stall_q    <= 3'd0;
            core_stall <= 1'b0;
            ready_irq  <= 1'b0;
        end else begin
            if (do_read) begin
                stall_q    <= RD_M1[2:0];
                core_stall <= 1'b1;
            end else if (start) begin
                stall_q    <= WR_M1[2:0];
                core_stall <= 1'b1;
            end else if (stall_q != 3'd0) begin
                stall_q    <= stall_q - 3'd1;
            end else begin
                core_stall <= 1'b0;
            end
            ready_irq <= rdy_ie_q && !prog_q && !start;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read
    reg [31:0] rd_mux;
    reg        rd_ok;
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (s_axi_araddr)
            `EAC_OFS_ADDR_LOW:  rd_mux[7:0] = addr_q[7:0];
            `EAC_OFS_ADDR_HIGH: rd_mux[ADDR_W-9:0] = addr_q[ADDR_W-1:8];
            `EAC_OFS_VALUE:     rd_mux[7:0] = value_q;
            `EAC_OFS_CTRL:      rd_mux[7:0] = {2'b00, mode_q, rdy_ie_q,
                                               arm_q, prog_q, 1'b0};
            `EAC_OFS_STATUS:    rd_mux[1:0] = {core_stall, prog_q};
            default:            rd_ok = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `EAC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_ok ? `EAC_RESP_OKAY : `EAC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// ===== eac_ctrl_checker.sv
/* port checker for eac_ctrl: bus handshakes, core stalls, reset state.
   assumes the single aclk domain; bound onto every eac_ctrl. */
`timescale 1ns/1ps
`default_nettype none
`include "eac_defines.vh"
module eac_ctrl_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        por_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        core_stall,
    input wire logic        ready_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data not held");
    property p_b_time;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_time: assert property (p_b_time)
        else $error("write response late");
    property p_r_time; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_time: assert property (p_r_time)
        else $error("read response late");
    property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_w_block: assert property (p_w_block)
        else $error("write accepted during response");
    property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_r_block: assert property (p_r_block)
        else $error("read accepted during response");
    property p_err_zero;
        s_axi_rvalid && s_axi_rresp == `EAC_RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000;
    endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("error read carries data");
    // a stall lasts two cycles for a program start or four for a read
    property p_stall;
        $rose(core_stall) |-> core_stall[*2] ##1 (!core_stall or (core_stall[*2] ##1 !core_stall));
    endproperty
    a_stall: assert property (p_stall)
        else $error("core stall length wrong");
    property p_rst; disable iff (!por_n)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !core_stall && !ready_irq; endproperty
    a_rst: assert property (p_rst)
        else $error("outputs active in reset");
    c_rd_stall: cover property (core_stall[*4]);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == `EAC_RESP_SLVERR);
    c_irq: cover property ($rose(ready_irq));
endmodule
bind eac_ctrl eac_ctrl_checker i_eac_ctrl_checker (
    .aclk, .aresetn, .por_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .core_stall, .ready_irq
);
`default_nettype wire

// ===== eac_core_model.sv
/* processor core model: axi4-lite master issuing single register accesses.
   assumes tasks are entered right after a rising aclk edge. */
`timescale 1ns/1ps
`default_nettype none
module eac_core_model (
    input  wire logic        aclk,
    output logic [7:0]  s_axi_awaddr,
    output logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    output logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic        s_axi_bready,
    output logic [7:0]  s_axi_araddr,
    output logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic        s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_araddr, s_axi_arvalid} = '0;
        // response readies stay high: no re-raise in the step that drops them
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_wstrb   <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule
`default_nettype wire

// ===== eac_ctrl_tb.sv
/* self-checking bench for eac_ctrl with a short tick and short op counts.
   assumes eac_core_model as bus master and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
`include "eac_defines.vh"
module eac_ctrl_tb;
    localparam integer D = 4, TA = 8, TS = 4;
    logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0;
    wire logic [7:0] s_axi_awaddr, s_axi_araddr;
    wire logic [31:0] s_axi_wdata, s_axi_rdata;
    wire logic [3:0] s_axi_wstrb;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire logic core_stall, ready_irq;
    int miscompares = 0, compares = 0, run = 0, slen = 0, lo = 0, ilen = 0;
    logic [31:0] rv;
    logic [1:0] rsp;
    always #2 aclk = ~aclk;
    eac_ctrl #(.TICK_DIV(D), .T_ATOMIC(TA), .T_SPLIT(TS)) i_eac_ctrl (.aclk, .aresetn, .por_n,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .core_stall, .ready_irq);
    eac_core_model i_eac_core_model (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // last stall run and last idle-request gap, measured in cycles
    always @(posedge aclk) begin
        run <= core_stall ? run + 1 : 0;
        if (!core_stall && run != 0) slen <= run;
        lo <= (ready_irq || !aresetn) ? 0 : lo + 1;
        if (ready_irq && lo != 0) ilen <= lo;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
        i_eac_core_model.wr(a, d, rsp);
        chk("bresp", rsp, e);
    endtask
    task automatic r(input logic [7:0] a);
        i_eac_core_model.rd(a, rv, rsp);
    endtask
    task automatic idle();
        int n;
        n = 0;
        do begin
            r(`EAC_OFS_STATUS);
            n++;
        end while (rv[0] !== 1'b0 && n < 100);
        chk("idle", n < 100, 32'h0000_0001);
    endtask
    task automatic prg(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m);
        idle();
        w(`EAC_OFS_ADDR_LOW, a[7:0]);
        w(`EAC_OFS_ADDR_HIGH, {7'h00, a[8]});
        w(`EAC_OFS_VALUE, d);
        w(`EAC_OFS_CTRL, {2'h0, m, 4'h8});
        w(`EAC_OFS_CTRL, {2'h0, m, 4'hC});
        w(`EAC_OFS_CTRL, {2'h0, m, 4'hA});
    endtask
    task automatic rdb(input logic [8:0] a, input logic [7:0] e);
        idle();
        w(`EAC_OFS_ADDR_LOW, a[7:0]);
        w(`EAC_OFS_ADDR_HIGH, {7'h00, a[8]});
        w(`EAC_OFS_CTRL, 8'h09);
        r(`EAC_OFS_VALUE);
        chk("byte", rv[7:0], e);
        repeat (4) @(posedge aclk);
        chk("rd_stall", slen, `EAC_RD_STALL);
    endtask
    task automatic plen(input int t);
        repeat (2) @(posedge aclk);
        chk("prog_len", ilen >= (t - 1) * D && ilen <= t * D + 1, 32'h0000_0001);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        r(`EAC_OFS_CTRL);
        chk("ctrl_rst", rv[5:0], 6'h00);
        r(`EAC_OFS_STATUS);
        chk("status_rst", rv[1:0], 2'h0);
    endtask
    task automatic t_atomic();
        prg(9'h1A5, 8'h3C, `EAC_MODE_ATOMIC);
        r(`EAC_OFS_CTRL);
        chk("prog_held", rv[1], 1'h1);
        w(`EAC_OFS_ADDR_LOW, 8'h00);
        w(`EAC_OFS_CTRL, 8'h18);
        w(`EAC_OFS_CTRL, 8'h0C);
        w(`EAC_OFS_CTRL, 8'h0A);
        r(`EAC_OFS_CTRL);
        chk("mode_locked", rv[5:4], `EAC_MODE_ATOMIC);
        chk("prog_stall", slen, `EAC_WR_STALL);
        idle();
        plen(TA);
        rdb(9'h1A5, 8'h3C);
    endtask
    task automatic t_split();
        prg(9'h055, 8'h00, `EAC_MODE_ERASE);
        idle();
        plen(TS);
        rdb(9'h055, `EAC_ERASED_BYTE);
        prg(9'h055, 8'h5A, `EAC_MODE_WRITE);
        idle();
        plen(TS);
        rdb(9'h055, 8'h5A);
    endtask
    task automatic t_guard();
        prg(9'h0AA, 8'h11, `EAC_MODE_RSVD);
        r(`EAC_OFS_STATUS);
        chk("rsvd_busy", rv[0], 1'h0);
        chk("rsvd_irq", ready_irq, 1'h1);
        w(`EAC_OFS_CTRL, 8'h0C);
        repeat (8) @(posedge aclk);
        r(`EAC_OFS_CTRL);
        chk("arm_clear", rv[2], 1'h0);
        w(`EAC_OFS_CTRL, 8'h0A);
        r(`EAC_OFS_STATUS);
        chk("late_strobe", rv[0], 1'h0);
        w(8'h00, 8'h55, `EAC_RESP_SLVERR);
        r(8'h18);
        chk("rd_err_resp", rsp, `EAC_RESP_SLVERR);
        chk("rd_err_data", rv, 32'h0000_0000);
    endtask
    // system reset must not cut a running erase short
    task automatic t_soft_reset();
        prg(9'h0F0, 8'h00, `EAC_MODE_ERASE);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        r(`EAC_OFS_CTRL);
        chk("mode_kept", rv[5:4], `EAC_MODE_ERASE);
        chk("prog_kept", rv[1], 1'h1);
        rdb(9'h0F0, `EAC_ERASED_BYTE);
    endtask
    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_atomic();
        t_split();
        t_guard();
        t_soft_reset();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        finish_test();
    end
endmodule
`default_nettype wire
